// File: rtl/pcrd_pkg.sv
// Package with frame layouts, codes, faults and register map of the decoder
package pcrd_pkg;

  // Identifier word field positions
  localparam int PNU_LSB      = 0;
  localparam int PNU_MSB      = 10;
  localparam int RESERVED_BIT = 11;
  localparam int CODE_LSB     = 12;
  localparam int CODE_MSB     = 15;

  // Parameter number limits
  localparam logic [16:0] PARAM_NUM_MIN = 17'h00001;
  localparam logic [16:0] PARAM_NUM_MAX = 17'h0F22F;

  // Page offsets applied per page bit
  localparam logic [16:0] PAGE_OFS_B7 = 17'h007D0;
  localparam logic [16:0] PAGE_OFS_B4 = 17'h00FA0;
  localparam logic [16:0] PAGE_OFS_B5 = 17'h01F40;
  localparam logic [16:0] PAGE_OFS_B6 = 17'h03E80;
  localparam logic [16:0] PAGE_OFS_B2 = 17'h07D00;
  localparam logic [16:0] PAGE_OFS_B3 = 17'h0FA00;

  // Request codes
  localparam logic [3:0] REQ_NONE      = 4'h0;
  localparam logic [3:0] REQ_READ      = 4'h1;
  localparam logic [3:0] REQ_WR_W      = 4'h2;
  localparam logic [3:0] REQ_WR_D      = 4'h3;
  localparam logic [3:0] REQ_DESC      = 4'h4;
  localparam logic [3:0] REQ_UNSUP_A   = 4'h5;
  localparam logic [3:0] REQ_ARR_READ  = 4'h6;
  localparam logic [3:0] REQ_ARR_WR_W  = 4'h7;
  localparam logic [3:0] REQ_ARR_WR_D  = 4'h8;
  localparam logic [3:0] REQ_COUNT     = 4'h9;
  localparam logic [3:0] REQ_UNSUP_B   = 4'hA;
  localparam logic [3:0] REQ_NV_ARR_D  = 4'hB;
  localparam logic [3:0] REQ_NV_ARR_W  = 4'hC;
  localparam logic [3:0] REQ_NV_WR_D   = 4'hD;
  localparam logic [3:0] REQ_NV_WR_W   = 4'hE;
  localparam logic [3:0] REQ_UNSUP_C   = 4'hF;

  // Response codes
  localparam logic [3:0] RSP_NONE    = 4'h0;
  localparam logic [3:0] RSP_WORD    = 4'h1;
  localparam logic [3:0] RSP_DWORD   = 4'h2;
  localparam logic [3:0] RSP_DESC    = 4'h3;
  localparam logic [3:0] RSP_ARR_W   = 4'h4;
  localparam logic [3:0] RSP_ARR_D   = 4'h5;
  localparam logic [3:0] RSP_COUNT   = 4'h6;
  localparam logic [3:0] RSP_REFUSED = 4'h7;
  localparam logic [3:0] RSP_NO_AUTH = 4'h8;

  // Fault numbers
  localparam logic [7:0] FLT_NO_PARAM   = 8'h00;
  localparam logic [7:0] FLT_READ_ONLY  = 8'h01;
  localparam logic [7:0] FLT_RANGE      = 8'h02;
  localparam logic [7:0] FLT_SUBINDEX   = 8'h03;
  localparam logic [7:0] FLT_NO_ARRAY   = 8'h04;
  localparam logic [7:0] FLT_TYPE       = 8'h05;
  localparam logic [7:0] FLT_RESET_ONLY = 8'h06;
  localparam logic [7:0] FLT_DESC_FIXED = 8'h07;
  localparam logic [7:0] FLT_NO_MASTER  = 8'h0B;
  localparam logic [7:0] FLT_KEYWORD    = 8'h0C;
  localparam logic [7:0] FLT_OP_STATE   = 8'h11;
  localparam logic [7:0] FLT_INACTIVE   = 8'h65;
  localparam logic [7:0] FLT_NARROW     = 8'h66;
  localparam logic [7:0] FLT_BAD_VALUE  = 8'h68;
  localparam logic [7:0] FLT_UNSUPPORT  = 8'h6A;
  localparam logic [7:0] FLT_OP_LIM_LO  = 8'hC8;
  localparam logic [7:0] FLT_OP_LIM_HI  = 8'hC9;
  localparam logic [7:0] FLT_RIGHTS     = 8'hCC;

  // Register map
  localparam int          REG_ADDR_W   = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_ANSWERED = 8'h08;
  localparam logic [7:0]  REG_REFUSED  = 8'h0C;
  localparam logic [4:0]  CTRL_RESET   = 5'h06;
  localparam int          CTRL_CYCLIC  = 0;
  localparam int          CTRL_MASTER  = 1;
  localparam int          CTRL_RIGHTS  = 2;
  localparam int          CTRL_LOCKED  = 3;
  localparam int          CTRL_NARROW  = 4;

  // Four-word parameter channel
  typedef struct packed {
    logic [15:0] paramIdentWord;
    logic [15:0] paramIndexWord;
    logic [15:0] valueHighWord;
    logic [15:0] valueLowWord;
  } pcrd_frame_type;

  // Request to the parameter store
  typedef struct packed {
    logic [16:0] paramNumber;
    logic [7:0]  subIndex;
    logic [31:0] writeValue;
    logic        isWrite;
    logic        isDouble;
    logic        isArray;
    logic        persist;
    logic        descRead;
    logic        countRead;
  } pcrd_store_req_type;

  // Answer of the parameter store
  typedef struct packed {
    logic        exists;
    logic        deactivated;
    logic        isArray;
    logic        isDouble;
    logic        readOnly;
    logic        subBad;
    logic        keyMissing;
    logic        stateBlock;
    logic        resetOnly;
    logic        valueBad;
    logic        rangeBad;
    logic        opLimitLow;
    logic        opLimitHigh;
    logic        descLocked;
    logic [31:0] readValue;
  } pcrd_store_info_type;

endpackage

// File: rtl/pcrd_page_offset.sv
// Absolute parameter number from number field and page bits of the index word
`timescale 1ns/1ps
module pcrd_page_offset (
  input  wire logic [10:0] paramNumberField,
  input  wire logic [15:0] paramIndexWord,
  input  wire logic        cyclicMode,
  output logic      [16:0] paramNumber,
  output logic      [7:0]  subIndex
);
  import pcrd_pkg::*;

  logic [7:0]  pageByte;
  logic [16:0] pageOffset;

  // Page byte low in cyclic transfer, high in acyclic transfer
  assign pageByte = cyclicMode ? paramIndexWord[7:0] : paramIndexWord[15:8];
  assign subIndex = cyclicMode ? paramIndexWord[15:8] : paramIndexWord[7:0];

  // Sum of offsets of every set page bit
  assign pageOffset = (pageByte[7] ? PAGE_OFS_B7 : 17'h00000)
                    + (pageByte[4] ? PAGE_OFS_B4 : 17'h00000)
                    + (pageByte[5] ? PAGE_OFS_B5 : 17'h00000)
                    + (pageByte[6] ? PAGE_OFS_B6 : 17'h00000)
                    + (pageByte[2] ? PAGE_OFS_B2 : 17'h00000)
                    + (pageByte[3] ? PAGE_OFS_B3 : 17'h00000);
  assign paramNumber = pageOffset + {6'h00, paramNumberField};
endmodule

// File: rtl/pcrd_decoder.sv
// Parameter channel request decoder and response generator
`timescale 1ns/1ps

module pcrd_decoder (
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire logic [pcrd_pkg::REG_ADDR_W-1:0]     regAddr,
  input  wire logic [31:0]                         regWrData,
  input  wire logic                                regWrStb,
  input  wire logic                                regRdStb,
  output logic      [31:0]                         regRdData,
  input  wire logic                                frameStb,
  input  wire pcrd_pkg::pcrd_frame_type            reqFrame,
  output pcrd_pkg::pcrd_frame_type                 respFrame,
  output logic                                     respStb,
  output logic                                     storeReqStb,
  output pcrd_pkg::pcrd_store_req_type             storeReq,
  input  wire logic                                storeAck,
  input  wire pcrd_pkg::pcrd_store_info_type       storeInfo
);
  import pcrd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT
  } pcrd_state_type;

  pcrd_state_type      state_q;
  pcrd_state_type      state_d;
  logic [4:0]          ctrl_q;
  logic [31:0]         regRdData_q;
  pcrd_frame_type      respFrame_q;
  pcrd_frame_type      respFrame_d;
  logic                respStb_q;
  logic                storeReqStb_q;
  pcrd_store_req_type  storeReq_q;
  pcrd_store_req_type  storeReq_d;
  logic [3:0]          reqCode_q;
  logic [15:0]         identEcho_q;
  logic [15:0]         indexEcho_q;
  logic [3:0]          lastResp_q;
  logic [7:0]          lastFault_q;
  logic [15:0]         answered_q;
  logic [15:0]         refused_q;

  // Incoming request decode
  wire  [3:0]  reqCode     = reqFrame.paramIdentWord[CODE_MSB:CODE_LSB];
  wire  [10:0] pnuField    = reqFrame.paramIdentWord[PNU_MSB:PNU_LSB];
  wire         isUnsup     = (reqCode == REQ_UNSUP_A) | (reqCode == REQ_UNSUP_B)
                           | (reqCode == REQ_UNSUP_C);
  wire         isPersist   = (reqCode >= REQ_NV_ARR_D) & (reqCode <= REQ_NV_WR_W);
  wire         isArrWr     = (reqCode == REQ_ARR_WR_W) | (reqCode == REQ_ARR_WR_D);
  wire         isWrCode    = (reqCode == REQ_WR_W) | (reqCode == REQ_WR_D) | isArrWr | isPersist;
  wire         isDblCode   = (reqCode == REQ_WR_D) | (reqCode == REQ_ARR_WR_D)
                           | (reqCode == REQ_NV_ARR_D) | (reqCode == REQ_NV_WR_D);
  wire         isArrCode   = (reqCode == REQ_ARR_READ) | isArrWr
                           | (reqCode == REQ_NV_ARR_D) | (reqCode == REQ_NV_ARR_W);
  wire  [16:0] paramNumber;
  wire  [7:0]  subIndex;

  // Page offset and subindex extraction
  pcrd_page_offset uPageOffset (
    .paramNumberField (pnuField),
    .paramIndexWord   (reqFrame.paramIndexWord),
    .cyclicMode       (ctrl_q[CTRL_CYCLIC]),
    .paramNumber      (paramNumber),
    .subIndex         (subIndex)
  );

  // Value of a write: 32-bit high then low, 16-bit in the low word
  wire  [31:0] wrValue = isDblCode ? {reqFrame.valueHighWord, reqFrame.valueLowWord}
                                   : {16'h0000, reqFrame.valueLowWord};

  // Store request built from the frame
  always_comb begin
    storeReq_d            = storeReq_q;
    storeReq_d.paramNumber = paramNumber;
    storeReq_d.subIndex   = subIndex;
    storeReq_d.writeValue = wrValue;
    storeReq_d.isWrite    = isWrCode;
    storeReq_d.isDouble   = isDblCode;
    storeReq_d.isArray    = isArrCode;
    storeReq_d.persist    = isPersist;
    storeReq_d.descRead   = (reqCode == REQ_DESC);
    storeReq_d.countRead  = (reqCode == REQ_COUNT);
  end

  // Fault checks on the store answer
  wire wr        = storeReq_q.isWrite;
  wire numBad    = (storeReq_q.paramNumber < PARAM_NUM_MIN)
                 | (storeReq_q.paramNumber > PARAM_NUM_MAX);
  wire arrMisuse = storeReq_q.isArray & ~storeInfo.isArray
                 & (storeReq_q.subIndex != 8'h00);
  wire typeBad   = wr & (storeReq_q.isDouble != storeInfo.isDouble);
  wire readDbl   = storeInfo.isDouble & ((reqCode_q == REQ_READ)
                 | (reqCode_q == REQ_ARR_READ) | storeReq_q.descRead);
  wire narrowBad = ctrl_q[CTRL_NARROW] & readDbl;

  // Checks that only matter for write requests
  wire noMaster  = wr & ~ctrl_q[CTRL_MASTER];
  wire noRights  = wr & ~ctrl_q[CTRL_RIGHTS];
  wire descWr    = wr & storeInfo.descLocked;
  wire roWr      = wr & storeInfo.readOnly;
  wire keyWr     = wr & storeInfo.keyMissing;
  wire stateWr   = wr & storeInfo.stateBlock;
  wire resetWr   = wr & storeInfo.resetOnly;
  wire valueWr   = wr & storeInfo.valueBad;
  wire rangeWr   = wr & storeInfo.rangeBad;
  wire limLoWr   = wr & storeInfo.opLimitLow;
  wire limHiWr   = wr & storeInfo.opLimitHigh;
  wire wrFault   = noMaster | noRights | descWr | roWr
                 | keyWr | stateWr | resetWr | valueWr
                 | rangeWr | limLoWr | limHiWr;

  // Fault priority: existence, shape, authority, then value checks
  wire       faultHit =
      numBad | ~storeInfo.exists | storeInfo.deactivated | arrMisuse | storeInfo.subBad
    | typeBad | wrFault | narrowBad;
  wire [7:0] faultNum =
      (numBad | ~storeInfo.exists)       ? FLT_NO_PARAM   :
      storeInfo.deactivated              ? FLT_INACTIVE   :
      arrMisuse                          ? FLT_NO_ARRAY   :
      storeInfo.subBad                   ? FLT_SUBINDEX   :
      typeBad                            ? FLT_TYPE       :
      (wr & storeInfo.descLocked)        ? FLT_DESC_FIXED :
      (wr & storeInfo.readOnly)          ? FLT_READ_ONLY  :
      (wr & ~ctrl_q[CTRL_MASTER])        ? FLT_NO_MASTER  :
      (wr & ~ctrl_q[CTRL_RIGHTS])        ? FLT_RIGHTS     :
      (wr & storeInfo.keyMissing)        ? FLT_KEYWORD    :
      (wr & storeInfo.stateBlock)        ? FLT_OP_STATE   :
      (wr & storeInfo.resetOnly)         ? FLT_RESET_ONLY :
      (wr & storeInfo.valueBad)          ? FLT_BAD_VALUE  :
      (wr & storeInfo.rangeBad)          ? FLT_RANGE      :
      (wr & storeInfo.opLimitLow)        ? FLT_OP_LIM_LO  :
      (wr & storeInfo.opLimitHigh)       ? FLT_OP_LIM_HI  :
                                           FLT_NARROW;

  // Positive response code per request code
  logic [3:0] posCode;
  always_comb begin
    case (reqCode_q)
      REQ_READ:     posCode = storeInfo.isDouble ? RSP_DWORD : RSP_WORD;
      REQ_WR_W:     posCode = RSP_WORD;
      REQ_WR_D:     posCode = RSP_DWORD;
      REQ_DESC:     posCode = RSP_DESC;
      REQ_ARR_READ: posCode = storeInfo.isDouble ? RSP_ARR_D : RSP_ARR_W;
      REQ_ARR_WR_W: posCode = RSP_ARR_W;
      REQ_ARR_WR_D: posCode = RSP_ARR_D;
      REQ_COUNT:    posCode = RSP_COUNT;
      REQ_NV_ARR_D: posCode = RSP_ARR_D;
      REQ_NV_ARR_W: posCode = RSP_ARR_W;
      REQ_NV_WR_D:  posCode = RSP_DWORD;
      REQ_NV_WR_W:  posCode = RSP_WORD;
      default:      posCode = RSP_NONE;
    endcase
  end

  // Value carried by a positive answer
  wire [31:0] posValue =
      wr                                  ? storeReq_q.writeValue :
      (storeReq_q.countRead | ~readDbl)   ? {16'h0000, storeInfo.readValue[15:0]} :
                                            storeInfo.readValue;

  // Identifier echo with new code and reserved bit forced low
  function automatic logic [15:0] identWith(input logic [3:0] code, input logic [15:0] ident);
    identWith = {code, 1'b0, ident[PNU_MSB:PNU_LSB]};
  endfunction

  // Next state, response and store request
  logic       storeReqStb_d;
  logic       respStb_d;
  logic [3:0] lastResp_d;
  logic [7:0] lastFault_d;
  logic       cntAns;
  logic       cntRef;
  always_comb begin
    state_d       = state_q;
    respFrame_d   = respFrame_q;
    respStb_d     = 1'b0;
    storeReqStb_d = 1'b0;
    lastResp_d    = lastResp_q;
    lastFault_d   = lastFault_q;
    cntAns        = 1'b0;
    cntRef        = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (frameStb) begin
          if (reqCode == REQ_NONE) begin
            respFrame_d = '0;
            respStb_d   = 1'b1;
            lastResp_d  = RSP_NONE;
          end else if (ctrl_q[CTRL_LOCKED]) begin
            respFrame_d.paramIdentWord = identWith(RSP_NO_AUTH, reqFrame.paramIdentWord);
            respFrame_d.paramIndexWord = reqFrame.paramIndexWord;
            respFrame_d.valueHighWord  = 16'h0000;
            respFrame_d.valueLowWord   = 16'h0000;
            respStb_d   = 1'b1;
            lastResp_d  = RSP_NO_AUTH;
            cntAns      = 1'b1;
            cntRef      = 1'b1;
          end else if (isUnsup) begin
            respFrame_d.paramIdentWord = identWith(RSP_REFUSED, reqFrame.paramIdentWord);
            respFrame_d.paramIndexWord = reqFrame.paramIndexWord;
            respFrame_d.valueHighWord  = 16'h0000;
            respFrame_d.valueLowWord   = {8'h00, FLT_UNSUPPORT};
            respStb_d   = 1'b1;
            lastResp_d  = RSP_REFUSED;
            lastFault_d = FLT_UNSUPPORT;
            cntAns      = 1'b1;
            cntRef      = 1'b1;
          end else begin
            storeReqStb_d = 1'b1;
            state_d       = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Frames in this state are dropped; the master repeats them
        if (storeAck) begin
          respFrame_d.paramIndexWord = indexEcho_q;
          if (faultHit) begin
            respFrame_d.paramIdentWord = identWith(RSP_REFUSED, identEcho_q);
            respFrame_d.valueHighWord  = 16'h0000;
            respFrame_d.valueLowWord   = {8'h00, faultNum};
            lastResp_d  = RSP_REFUSED;
            lastFault_d = faultNum;
            cntRef      = 1'b1;
          end else begin
            respFrame_d.paramIdentWord = identWith(posCode, identEcho_q);
            respFrame_d.valueHighWord  = posValue[31:16];
            respFrame_d.valueLowWord   = posValue[15:0];
            lastResp_d  = posCode;
          end
          respStb_d = 1'b1;
          cntAns    = 1'b1;
          state_d   = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Status word: waiting flag, last response code, last fault
  wire        waiting    = (state_q == ST_WAIT);
  wire [31:0] statusWord = {19'h00000, waiting, lastResp_q, lastFault_q};

  // Register decode
  wire        hitCtrl = (regAddr == REG_CTRL);
  wire [31:0] rdMux   =
      hitCtrl                   ? {27'h0000000, ctrl_q} :
      (regAddr == REG_STATUS)   ? statusWord :
      (regAddr == REG_ANSWERED) ? {16'h0000, answered_q} :
      (regAddr == REG_REFUSED)  ? {16'h0000, refused_q} :
                                  32'h00000000;

  // Control register and read data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q      <= CTRL_RESET;
      regRdData_q <= 32'h00000000;
    end else begin
      if (regWrStb && hitCtrl) begin
        ctrl_q <= regWrData[4:0];
      end
      regRdData_q <= regRdStb ? rdMux : 32'h00000000;
    end
  end

  // Request sequencing
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q       <= ST_IDLE;
      respFrame_q   <= '0;
      respStb_q     <= 1'b0;
      storeReqStb_q <= 1'b0;
      storeReq_q    <= '0;
      reqCode_q     <= REQ_NONE;
      identEcho_q   <= 16'h0000;
      indexEcho_q   <= 16'h0000;
    end else begin
      state_q       <= state_d;
      respFrame_q   <= respFrame_d;
      respStb_q     <= respStb_d;
      storeReqStb_q <= storeReqStb_d;
      if (storeReqStb_d) begin
        storeReq_q  <= storeReq_d;
        reqCode_q   <= reqCode;
        identEcho_q <= reqFrame.paramIdentWord;
        indexEcho_q <= reqFrame.paramIndexWord;
      end
    end
  end

  // Status and counters
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastResp_q  <= RSP_NONE;
      lastFault_q <= 8'h00;
      answered_q  <= 16'h0000;
      refused_q   <= 16'h0000;
    end else begin
      lastResp_q  <= lastResp_d;
      lastFault_q <= lastFault_d;
      answered_q  <= answered_q + {15'h0000, cntAns};
      refused_q   <= refused_q + {15'h0000, cntRef};
    end
  end

  // Outputs straight from flip-flops
  assign regRdData   = regRdData_q;
  assign respFrame   = respFrame_q;
  assign respStb     = respStb_q;
  assign storeReqStb = storeReqStb_q;
  assign storeReq    = storeReq_q;
endmodule

// File: verification/pcrd_decoder_assertions.sv
// Checker of decoder frame timing and answer fields
`timescale 1ns/1ps
module pcrd_decoder_assertions (
  input wire logic                            core_clk,
  input wire logic                            sys_rst,
  input wire logic [pcrd_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0]                     regWrData,
  input wire logic                            regWrStb,
  input wire logic                            frameStb,
  input wire pcrd_pkg::pcrd_frame_type        reqFrame,
  input wire pcrd_pkg::pcrd_frame_type        respFrame,
  input wire logic                            respStb,
  input wire logic                            storeReqStb,
  input wire logic                            storeAck
);
  import pcrd_pkg::*;
  logic        busy_q;
  logic        lock_q;
  logic [10:0] pnu_q;
  wire         acc   = frameStb && !busy_q;
  wire  [3:0]  code  = reqFrame.paramIdentWord[15:12];
  wire  [3:0]  rsp   = respFrame.paramIdentWord[15:12];
  wire         unsup = code == 4'h5 || code == 4'hA || code == 4'hF;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Shadow of pending request, channel lock and number field
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      lock_q <= 1'b0;
      pnu_q  <= 11'h000;
    end else begin
      busy_q <= acc || (busy_q && !respStb);
      lock_q <= (regWrStb && regAddr == REG_CTRL) ? regWrData[CTRL_LOCKED] : lock_q;
      pnu_q  <= acc ? reqFrame.paramIdentWord[10:0] : pnu_q;
    end
  end
  resv_zero_a: assert property (respStb |-> !respFrame.paramIdentWord[11])
    else $error("reserved bit set in answer");
  idle_answer_a: assert property (acc && code == REQ_NONE |=> respStb && respFrame == '0)
    else $error("idle answer not zero");
  unsup_fault_a: assert property (acc && unsup && !lock_q |=> respStb
    && rsp == RSP_REFUSED && respFrame.valueLowWord == {8'h00, FLT_UNSUPPORT})
    else $error("unsupported code not refused");
  store_query_a: assert property (acc && !unsup && code != REQ_NONE && !lock_q
    |=> storeReqStb && !respStb)
    else $error("store not queried");
  ack_answer_a: assert property (busy_q && storeAck && !respStb |=> respStb)
    else $error("no answer after store ack");
  pnu_echo_a: assert property (respStb && rsp != RSP_NONE
    |-> respFrame.paramIdentWord[10:0] == pnu_q)
    else $error("number field not echoed");
  refuse_high_a: assert property (respStb && rsp == RSP_REFUSED
    |-> respFrame.valueHighWord == 16'h0000 && respFrame.valueLowWord[15:8] == 8'h00)
    else $error("refusal value words wrong");
  locked_code_a: assert property (acc && lock_q && code != REQ_NONE
    |=> respStb && rsp == RSP_NO_AUTH)
    else $error("locked channel not answered with no-authority code");
endmodule
bind pcrd_decoder pcrd_decoder_assertions chk (
  .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .frameStb,
  .reqFrame, .respFrame, .respStb, .storeReqStb, .storeAck
);

// File: verification/pcrd_store_model.sv
// Parameter store model answering queries after a short or long delay
`timescale 1ns/1ps
module pcrd_store_model (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         storeReqStb,
  input  wire logic                         exists,
  input  wire logic                         dblSel,
  input  wire logic                         roSel,
  input  wire logic [31:0]                  rdVal,
  output logic                              storeAck,
  output pcrd_pkg::pcrd_store_info_type     storeInfo
);
  import pcrd_pkg::*;
  logic [1:0]          cnt_q;
  logic                slow_q;
  pcrd_store_info_type info;
  // Flags of the addressed parameter; inverse pattern outside the ack
  assign info = '{exists: exists, isArray: 1'b1, isDouble: dblSel, readOnly: roSel,
                  readValue: rdVal, default: 1'b0};
  assign storeInfo = storeAck ? info : ~info;
  // Delay from strobe to ack alternates between two and four cycles
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q    <= 2'h0;
      slow_q   <= 1'b0;
      storeAck <= 1'b0;
    end else begin
      storeAck <= cnt_q == 2'h1;
      if (storeReqStb) begin
        cnt_q  <= slow_q ? 2'h3 : 2'h1;
        slow_q <= !slow_q;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the parameter channel decoder
`timescale 1ns/1ps
module testbench;
  import pcrd_pkg::*;
  logic                core_clk, sys_rst, regWrStb, regRdStb, frameStb, storeAck, storeReqStb;
  logic                exists, dblSel, roSel, respStb;
  logic [7:0]          regAddr, expSub;
  logic [31:0]         regWrData, regRdData, rdVal, rng, expVal;
  logic [16:0]         expPnu;
  logic [4:0]          ctl;
  pcrd_frame_type      reqFrame, respFrame;
  pcrd_store_req_type  storeReq;
  pcrd_store_info_type storeInfo;
  int                  fails, checked, nAns, nRef;
  pcrd_decoder uut (.core_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .frameStb, .reqFrame, .respFrame, .respStb, .storeReqStb, .storeReq, .storeAck, .storeInfo);
  pcrd_store_model store (.core_clk, .sys_rst, .storeReqStb, .exists, .dblSel, .roSel, .rdVal,
    .storeAck, .storeInfo);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reg_io(input logic [7:0] a, input logic [31:0] d, input bit rd);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= !rd;
    regRdStb <= rd;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    #1;
    if (rd) cmp(regRdData, d);
    @(posedge core_clk);
  endtask
  task automatic send(input logic [3:0] c, input bit lk, input bit cy);
    int          t[16] = '{0, 1, 1, 2, 3, 7, 4, 4, 5, 6, 7, 5, 4, 2, 1, 7};
    logic [10:0] f;
    logic [15:0] idx, eHi, eLo;
    logic [31:0] v;
    logic [7:0]  pg;
    logic [3:0]  ec;
    int          n, flt;
    bit          wr, dw;
    rng = xs(rng);
    f = 11'd1 + 11'(rng[31:22]);
    wr = c inside {2, 3, 7, 8, [11:14]};
    dw = c inside {3, 8, 11, 13};
    idx = cy ? {rng[15:8], rng[7:0] & 8'h90} : {rng[15:8] & 8'h90, rng[7:0]};
    pg = cy ? idx[7:0] : idx[15:8];
    expPnu = 17'(f) + (pg[7] ? 17'd2000 : 17'd0) + (pg[4] ? 17'd4000 : 17'd0);
    expSub = cy ? idx[15:8] : idx[7:0];
    v = dw ? xs(rng) : {16'h0000, rng[21:6]};
    expVal = v;
    rdVal <= xs(rng ^ 32'h0000_0001);
    reqFrame <= '{{c, 1'b0, f}, idx, v[31:16], v[15:0]};
    frameStb <= 1'b1;
    @(posedge core_clk);
    #1;
    frameStb <= (respStb !== 1'b1);
    for (n = 0; n < 20 && respStb !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
      frameStb <= (respStb !== 1'b1);
    end
    if (n == 20) begin
      fails++;
      stop_test();
    end
    ec = 4'(t[c]) + 4'((c == 1 || c == 6) && dblSel);
    flt = (c == 0) ? -1 : (t[c] == 7) ? 106 : !exists ? 0 : (wr && dw != dblSel) ? 5
        : (wr && roSel) ? 1 : (wr && !ctl[CTRL_MASTER]) ? 11
        : (wr && !ctl[CTRL_RIGHTS]) ? 204
        : (ctl[CTRL_NARROW] && dblSel && c inside {1, 4, 6}) ? 102 : -1;
    if (flt >= 0) ec = 4'h7;
    if (lk && c != 0) begin
      ec = 4'h8;
      flt = -1;
    end
    eHi = (ec == 2 || ec == 5 || (ec == 3 && dblSel))
        ? (wr ? v[31:16] : rdVal[31:16]) : 16'h0000;
    eLo = flt >= 0 ? 16'(flt) : (ec == 0 || ec == 8) ? 16'h0000 : wr ? v[15:0] : rdVal[15:0];
    nAns += (c != 0);
    nRef += (ec == 7 || ec == 8);
    cmp(respFrame.paramIdentWord, (ec == 0) ? 16'h0 : {ec, 1'b0, f});
    cmp(respFrame.paramIndexWord, (ec == 0) ? 16'h0000 : idx);
    cmp(respFrame.valueHighWord, eHi);
    cmp(respFrame.valueLowWord, eLo);
    @(posedge core_clk);
  endtask
  // Store query fields checked when issued
  always @(posedge core_clk) begin
    if (storeReqStb === 1'b1) begin
      cmp(storeReq.paramNumber, expPnu);
      cmp(storeReq.subIndex, expSub);
      cmp(storeReq.writeValue, expVal);
    end
  end
  initial begin
    {regAddr, regWrData, regWrStb, regRdStb, frameStb, reqFrame, rdVal} = '0;
    {exists, dblSel, roSel} = 3'h4;
    {fails, checked, nAns, nRef} = '0;
    rng = 32'hFCE0E5AF;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    reg_io(REG_CTRL, 32'h0000_0006, 1'b1);
    reg_io(8'h10, 32'h0000_0000, 1'b1);
    for (int s = 0; s < 8; s++) begin
      ctl = (s == 4) ? 5'h07 : (s == 5) ? 5'h0E : (s > 5) ? 5'h12 : 5'h06;
      if (s >= 4) reg_io(REG_CTRL, {27'h0000000, ctl}, 1'b0);
      dblSel <= s[0];
      roSel <= (s == 2);
      exists <= (s != 3);
      for (int c = 0; c < 16; c++) send(c[3:0], ctl[3], ctl[0]);
    end
    reg_io(REG_STATUS, {20'h00000, RSP_REFUSED, FLT_UNSUPPORT}, 1'b1);
    reg_io(REG_ANSWERED, nAns, 1'b1);
    reg_io(REG_REFUSED, nRef, 1'b1);
    stop_test();
  end
endmodule
